// *** logic/pmc_defs.svh ***
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// Purpose: object indexes, field positions, defaults and timing of the motion block
// Assumes: 100 MHz system clock
// Notes: indexes are the object dictionary addresses used on the object port

// ==========================================
// object indexes
`define PMC_IDX_CW 16'h6040
`define PMC_IDX_SW 16'h6041
`define PMC_IDX_QS_OPT 16'h605A
`define PMC_IDX_HALT_OPT 16'h605D
`define PMC_IDX_ERR_OPT 16'h605E
`define PMC_IDX_MODE 16'h6060
`define PMC_IDX_TPOS 16'h607A
`define PMC_IDX_PVEL 16'h6081
`define PMC_IDX_ACC 16'h6083
`define PMC_IDX_DEC 16'h6084
`define PMC_IDX_QS_DEC 16'h6085
`define PMC_IDX_PTYPE 16'h6086
`define PMC_IDX_SLIP 16'h60F8
`define PMC_IDX_TVEL 16'h60FF

// ==========================================
// control word bits
`define PMC_CW_QS_N 2
`define PMC_CW_NEW_SP 4
`define PMC_CW_IMMED 5
`define PMC_CW_REL 6
`define PMC_CW_HALT 8
`define PMC_CW_SHUTDOWN 16'h0006
`define PMC_CW_SWITCH_ON 16'h0007
`define PMC_CW_ENABLE 16'h000F
`define PMC_CW_STATE_MASK 16'h008F

// ==========================================
// status word bits and state codes
`define PMC_SW_REACHED 10
`define PMC_SW_SPEED 12
`define PMC_SW_SLIP 13
`define PMC_SW_DISABLED 16'h0040
`define PMC_SW_READY 16'h0021
`define PMC_SW_ON 16'h0023
`define PMC_SW_ENABLED 16'h0027
`define PMC_SW_QSTOP 16'h0007
`define PMC_SW_FAULT 16'h0008

// ==========================================
// modes and option codes
`define PMC_MODE_POS 8'h01
`define PMC_MODE_VEL 8'h03
`define PMC_QS_OPT_A 16'h0002
`define PMC_QS_OPT_B 16'h0004
`define PMC_OPT_QS_RAMP 16'h0002
`define PMC_PTYPE_LINEAR 16'h0000

// ==========================================
// defaults after reset
`define PMC_RST_QS_DEC 32'h00030D40
`define PMC_RST_PVEL 32'h0007D000
`define PMC_RST_ACC 32'h000186A0
`define PMC_RST_DEC 32'h000186A0
`define PMC_RST_SLIP 32'h00000200
`define PMC_RST_QS_OPT 16'h0002
`define PMC_RST_OPT 16'h0001

// ==========================================
// timing and monitors
`define PMC_CLK_NS 10
`define PMC_TICK_NS 1000000
`define PMC_TICKS_PER_S 32'h000003E8
`define PMC_VEL_WIN 32'h00000064
`define PMC_VEL_THR 32'h00000000
`endif

// *** logic/pmc_pkg.sv ***
// Purpose: types shared by the motion block and its users
// Assumes: pmc_defs.svh for numbers
// Notes: state of the top is one packed struct
package pmc_pkg;
   typedef enum logic [2:0] {
      DRV_DISABLED, DRV_READY, DRV_ON, DRV_ENABLED, DRV_QSTOP, DRV_FAULT
   } pmc_drv_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] index;
      logic [31:0] wdata;
   } pmc_obj_req_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic rvalid;
      logic refused;
   } pmc_obj_rsp_t;

   typedef struct packed {
      pmc_drv_t drv;
      logic [15:0] cw;
      logic [7:0] mode;
      logic [15:0] qs_opt;
      logic [15:0] halt_opt;
      logic [15:0] err_opt;
      logic [15:0] ptype;
      logic [31:0] qs_dec;
      logic [31:0] acc;
      logic [31:0] dec;
      logic [31:0] pvel;
      logic [31:0] slip;
      logic signed [31:0] tpos;
      logic signed [31:0] tvel;
      logic signed [31:0] goal;
      logic signed [31:0] pend_goal;
      logic pend;
      logic ack;
      logic moving;
      logic signed [31:0] pos;
      logic signed [31:0] vel;
      logic [31:0] tick;
      logic [2:0] fault_sync;
      logic fault;
      pmc_obj_rsp_t rsp;
   } pmc_st_t;
endpackage

// *** logic/pmc_top.sv ***
// Purpose: profile position / profile velocity trajectory and object dictionary
// Assumes: vel_actual comes from sensor logic on sys_clk; fault_pin is asynchronous
// Notes: velocity and position demand update once per tick (1 ms by default)
`include "pmc_defs.svh"

module pmc_top #(
   parameter int TICK_CYC = `PMC_TICK_NS / `PMC_CLK_NS
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire pmc_pkg::pmc_obj_req_t obj_req,
   output pmc_pkg::pmc_obj_rsp_t obj_rsp,
   input wire logic signed [31:0] vel_actual,
   input wire logic fault_pin,
   output logic power_en,
   output logic signed [31:0] vel_demand,
   output logic signed [31:0] pos_demand,
   output logic [15:0] status_word
);
   // ==========================================
   // reset release
   logic [1:0] rst_sync;
   logic rst_q_b;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_q_b = rst_sync[1];

   function automatic logic [31:0] mag(input logic signed [31:0] v);
      mag = v[31] ? 32'(-v) : 32'(v);
   endfunction

   pmc_pkg::pmc_st_t st;
   pmc_pkg::pmc_st_t next_st;

   // ==========================================
   // combinational status and ramp terms
   logic pos_mode;
   logic vel_mode;
   logic halt;
   logic qstop;
   logic new_sp_rise;
   logic signed [31:0] req_goal;
   logic signed [31:0] rem;
   logic [31:0] rem_abs;
   logic [31:0] vabs;
   logic [31:0] acc_step;
   logic [31:0] dec_step;
   logic [31:0] use_dec;
   logic [31:0] brake;
   logic signed [31:0] v_goal;
   logic signed [31:0] v_next;
   logic signed [31:0] p_step;
   logic [15:0] sw;
   logic reached;
   logic zero_speed;
   logic slip_hit;

   always_comb begin
      pos_mode = st.mode == `PMC_MODE_POS;
      vel_mode = st.mode == `PMC_MODE_VEL;
      halt = st.cw[`PMC_CW_HALT];
      qstop = st.drv == pmc_pkg::DRV_QSTOP;
      new_sp_rise = obj_req.wr && obj_req.index == `PMC_IDX_CW
         && obj_req.wdata[`PMC_CW_NEW_SP] && !st.cw[`PMC_CW_NEW_SP];
      // relative targets add to the last commanded goal, not the live position
      req_goal = obj_req.wdata[`PMC_CW_REL] ? 32'(st.goal + st.tpos) : st.tpos;
      rem = 32'(st.goal - st.pos);
      rem_abs = mag(rem);
      vabs = mag(st.vel);
      acc_step = (st.acc / `PMC_TICKS_PER_S) | 32'h00000001;
      dec_step = (st.dec / `PMC_TICKS_PER_S) | 32'h00000001;
      use_dec = dec_step;
      if ((qstop && (st.qs_opt == `PMC_QS_OPT_A || st.qs_opt == `PMC_QS_OPT_B))
         || (st.drv == pmc_pkg::DRV_FAULT && st.err_opt == `PMC_OPT_QS_RAMP
         && st.halt_opt == `PMC_OPT_QS_RAMP)) begin
         use_dec = (st.qs_dec / `PMC_TICKS_PER_S) | 32'h00000001;
      end
      // coarse stopping distance; avoids a 64-bit product per tick
      brake = ((vabs / `PMC_TICKS_PER_S) * (vabs / dec_step)) >> 1;
      v_goal = 32'h00000000;
      if (st.drv == pmc_pkg::DRV_ENABLED && !halt) begin
         if (vel_mode) begin
            v_goal = st.tvel;
         end else if (pos_mode && st.moving) begin
            v_goal = 32'(rem_abs > brake ? st.pvel : acc_step);
            if (rem[31]) begin
               v_goal = 32'(-v_goal);
            end
         end
      end
      // linear ramp: fixed step toward goal, acceleration or deceleration
      if (st.vel < v_goal) begin
         v_next = 32'(st.vel + (st.vel[31] ? use_dec : acc_step));
         if (v_next > v_goal) begin
            v_next = v_goal;
         end
      end else begin
         v_next = 32'(st.vel - (st.vel[31] || st.vel == 0 ? acc_step : use_dec));
         if (v_next < v_goal) begin
            v_next = v_goal;
         end
      end
      p_step = 32'(st.vel / $signed(`PMC_TICKS_PER_S));
      if (p_step == 0 && st.vel != 0) begin
         p_step = st.vel[31] ? 32'hFFFFFFFF : 32'h00000001;
      end
      // sensor monitors: window on target, threshold on zero
      reached = halt ? st.vel == 0
         : pos_mode ? !st.moving : mag(32'(vel_actual - st.tvel)) <= `PMC_VEL_WIN;
      zero_speed = mag(vel_actual) <= `PMC_VEL_THR;
      slip_hit = mag(32'(st.vel - vel_actual)) >= st.slip;
      unique case (st.drv)
         pmc_pkg::DRV_DISABLED: sw = `PMC_SW_DISABLED;
         pmc_pkg::DRV_READY: sw = `PMC_SW_READY;
         pmc_pkg::DRV_ON: sw = `PMC_SW_ON;
         pmc_pkg::DRV_ENABLED: sw = `PMC_SW_ENABLED;
         pmc_pkg::DRV_QSTOP: sw = `PMC_SW_QSTOP;
         pmc_pkg::DRV_FAULT: sw = `PMC_SW_FAULT;
         default: sw = `PMC_SW_DISABLED;
      endcase
      sw[`PMC_SW_REACHED] = reached;
      if (pos_mode) begin
         sw[`PMC_SW_SPEED] = st.ack;
      end else if (vel_mode) begin
         sw[`PMC_SW_SPEED] = zero_speed;
         sw[`PMC_SW_SLIP] = slip_hit;
      end
   end

   // ==========================================
   // next state
   always_comb begin
      next_st = st;
      next_st.rsp.rvalid = 1'b0;
      next_st.rsp.refused = 1'b0;
      next_st.fault_sync = {st.fault_sync[1:0], fault_pin};
      if (st.fault_sync[2] == st.fault_sync[1]) begin
         next_st.fault = st.fault_sync[2];
      end

      if (obj_req.wr) begin
         unique case (obj_req.index)
            `PMC_IDX_CW: next_st.cw = obj_req.wdata[15:0];
            `PMC_IDX_MODE: next_st.mode = obj_req.wdata[7:0];
            `PMC_IDX_QS_OPT: next_st.qs_opt = obj_req.wdata[15:0];
            `PMC_IDX_HALT_OPT: next_st.halt_opt = obj_req.wdata[15:0];
            `PMC_IDX_ERR_OPT: next_st.err_opt = obj_req.wdata[15:0];
            `PMC_IDX_QS_DEC: next_st.qs_dec = obj_req.wdata;
            `PMC_IDX_ACC: next_st.acc = obj_req.wdata;
            `PMC_IDX_DEC: next_st.dec = obj_req.wdata;
            `PMC_IDX_PVEL: next_st.pvel = obj_req.wdata;
            `PMC_IDX_SLIP: next_st.slip = obj_req.wdata;
            `PMC_IDX_TPOS: next_st.tpos = obj_req.wdata;
            `PMC_IDX_TVEL: next_st.tvel = obj_req.wdata;
            `PMC_IDX_PTYPE: begin
               if (obj_req.wdata[15:0] != `PMC_PTYPE_LINEAR) begin
                  next_st.rsp.refused = 1'b1;
               end
            end
            default: next_st.rsp.refused = 1'b1;
         endcase
      end else if (obj_req.rd) begin
         next_st.rsp.rvalid = 1'b1;
         unique case (obj_req.index)
            `PMC_IDX_CW: next_st.rsp.rdata = {16'h0000, st.cw};
            `PMC_IDX_SW: next_st.rsp.rdata = {16'h0000, sw};
            `PMC_IDX_MODE: next_st.rsp.rdata = {24'h000000, st.mode};
            `PMC_IDX_QS_OPT: next_st.rsp.rdata = {16'h0000, st.qs_opt};
            `PMC_IDX_HALT_OPT: next_st.rsp.rdata = {16'h0000, st.halt_opt};
            `PMC_IDX_ERR_OPT: next_st.rsp.rdata = {16'h0000, st.err_opt};
            `PMC_IDX_QS_DEC: next_st.rsp.rdata = st.qs_dec;
            `PMC_IDX_ACC: next_st.rsp.rdata = st.acc;
            `PMC_IDX_DEC: next_st.rsp.rdata = st.dec;
            `PMC_IDX_PVEL: next_st.rsp.rdata = st.pvel;
            `PMC_IDX_SLIP: next_st.rsp.rdata = st.slip;
            `PMC_IDX_TPOS: next_st.rsp.rdata = st.tpos;
            `PMC_IDX_TVEL: next_st.rsp.rdata = st.tvel;
            `PMC_IDX_PTYPE: next_st.rsp.rdata = {16'h0000, st.ptype};
            default: begin
               next_st.rsp.rdata = 32'h00000000;
               next_st.rsp.rvalid = 1'b0;
               next_st.rsp.refused = 1'b1;
            end
         endcase
      end

      // power state follows the 06, 07, 0F sequence
      if (st.fault) begin
         next_st.drv = pmc_pkg::DRV_FAULT;
      end else if (obj_req.wr && obj_req.index == `PMC_IDX_CW) begin
         unique case (obj_req.wdata[15:0] & `PMC_CW_STATE_MASK)
            `PMC_CW_SHUTDOWN: next_st.drv = pmc_pkg::DRV_READY;
            `PMC_CW_SWITCH_ON: begin
               if (st.drv != pmc_pkg::DRV_DISABLED) begin
                  next_st.drv = pmc_pkg::DRV_ON;
               end
            end
            `PMC_CW_ENABLE: begin
               if (st.drv == pmc_pkg::DRV_ON || st.drv == pmc_pkg::DRV_ENABLED) begin
                  next_st.drv = pmc_pkg::DRV_ENABLED;
               end
            end
            default: begin
               if (st.drv == pmc_pkg::DRV_ENABLED && !obj_req.wdata[`PMC_CW_QS_N]) begin
                  next_st.drv = pmc_pkg::DRV_QSTOP;
               end else if (st.drv != pmc_pkg::DRV_QSTOP) begin
                  next_st.drv = pmc_pkg::DRV_DISABLED;
               end
            end
         endcase
      end else if (st.drv == pmc_pkg::DRV_FAULT) begin
         next_st.drv = pmc_pkg::DRV_DISABLED;
      end

      // set-point handshake; ack drops when the host clears the bit
      if (obj_req.wr && obj_req.index == `PMC_IDX_CW && !obj_req.wdata[`PMC_CW_NEW_SP]) begin
         next_st.ack = 1'b0;
      end
      // queued target starts on the cycle after the current move ends, so a late overwrite is kept
      if (st.pend && !st.moving && pos_mode && st.drv == pmc_pkg::DRV_ENABLED) begin
         next_st.goal = st.pend_goal;
         next_st.moving = 1'b1;
         next_st.pend = 1'b0;
         next_st.ack = 1'b1;
      end
      if (new_sp_rise && pos_mode && st.drv == pmc_pkg::DRV_ENABLED) begin
         if (!st.moving || obj_req.wdata[`PMC_CW_IMMED]) begin
            next_st.goal = req_goal;
            next_st.moving = 1'b1;
            next_st.ack = 1'b1;
            next_st.pend = 1'b0;
         end else begin
            next_st.pend_goal = req_goal;
            next_st.pend = 1'b1;
         end
      end

      // trajectory tick
      next_st.tick = st.tick + 32'h00000001;
      if (st.tick >= 32'(TICK_CYC - 1)) begin
         next_st.tick = 32'h00000000;
         next_st.vel = v_next;
         next_st.pos = 32'(st.pos + p_step);
         if (pos_mode && st.moving && rem_abs <= mag(p_step) && !halt) begin
            next_st.pos = st.goal;
            next_st.vel = 32'h00000000;
            next_st.moving = 1'b0;
         end
      end
      if (!pos_mode) begin
         next_st.moving = 1'b0;
         next_st.pend = 1'b0;
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge sys_clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         st <= '0;
         st.drv <= pmc_pkg::DRV_DISABLED;
         st.qs_opt <= `PMC_RST_QS_OPT;
         st.halt_opt <= `PMC_RST_OPT;
         st.err_opt <= `PMC_RST_OPT;
         st.ptype <= `PMC_PTYPE_LINEAR;
         st.qs_dec <= `PMC_RST_QS_DEC;
         st.acc <= `PMC_RST_ACC;
         st.dec <= `PMC_RST_DEC;
         st.pvel <= `PMC_RST_PVEL;
         st.slip <= `PMC_RST_SLIP;
      end else begin
         st <= next_st;
      end
   end

   assign obj_rsp = st.rsp;
   assign power_en = st.drv == pmc_pkg::DRV_ENABLED || st.drv == pmc_pkg::DRV_QSTOP;
   assign vel_demand = st.vel;
   assign pos_demand = st.pos;
   assign status_word = sw;
endmodule

// *** verif/pmc_top_properties.sv ***
// Purpose: concurrent checks on the motion block ports
// Assumes: object writes are one-cycle strobes on sys_clk
// Notes: shadow copies of a few objects are rebuilt from the write traffic
module pmc_top_properties #(
   parameter int TICK_CYC = 10
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire pmc_pkg::pmc_obj_req_t obj_req,
   input wire pmc_pkg::pmc_obj_rsp_t obj_rsp,
   input wire logic signed [31:0] vel_actual,
   input wire logic power_en,
   input wire logic signed [31:0] vel_demand,
   input wire logic [15:0] status_word
);
   typedef struct packed {
      logic [7:0] mode;
      logic [15:0] cw;
      logic [31:0] qs;
      logic [31:0] slip;
   } pmc_shadow_t;
   pmc_shadow_t sh;
   pmc_shadow_t next_sh;
   logic [31:0] slip_err;

   // ==========================================
   // shadow objects
   always_comb begin
      next_sh = sh;
      if (obj_req.wr) begin
         case (obj_req.index)
            16'h6060: next_sh.mode = obj_req.wdata[7:0];
            16'h6040: next_sh.cw = obj_req.wdata[15:0];
            16'h6085: next_sh.qs = obj_req.wdata;
            16'h60F8: next_sh.slip = obj_req.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sh <= {8'h00, 16'h0000, 32'h00030D40, 32'h00000200};
      end else begin
         sh <= next_sh;
      end
   end

   always_comb begin
      slip_err = (vel_demand >= vel_actual) ? vel_demand - vel_actual : vel_actual - vel_demand;
   end

   // ==========================================
   // properties
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_sp_rise;
      obj_req.wr && obj_req.index == 16'h6040 && obj_req.wdata[4] && !sh.cw[4]
         && sh.mode == 8'h01 && status_word[6:0] == 7'h27;
   endsequence

   sequence s_vel_steady;
      sh.mode == 8'h03 && $stable(vel_actual) && $stable(vel_demand);
   endsequence

   a_qs_readback:
      assert property (obj_req.rd && !obj_req.wr && obj_req.index == 16'h6085
         |=> obj_rsp.rvalid && obj_rsp.rdata == sh.qs)
      else $error("quick stop decel read mismatch");
   a_ptype_refuse:
      assert property (obj_req.wr && obj_req.index == 16'h6086 && obj_req.wdata[15:0] != 0
         |=> obj_rsp.refused)
      else $error("nonzero profile type accepted");
   a_ptype_zero:
      assert property (obj_req.rd && !obj_req.wr && obj_req.index == 16'h6086
         |=> obj_rsp.rvalid && obj_rsp.rdata == 32'h0)
      else $error("profile type not zero");
   a_enable_step:
      assert property (obj_req.wr && obj_req.index == 16'h6040 && obj_req.wdata[15:0] == 16'h000F
         && status_word[6:0] == 7'h23 |=> status_word[6:0] == 7'h27 && power_en)
      else $error("enable step missed");
   a_ack_idle:
      assert property (s_sp_rise ##0 status_word[10] |=> status_word[12])
      else $error("set-point not acknowledged");
   a_ack_immediate:
      assert property (s_sp_rise ##0 !status_word[10] && obj_req.wdata[5] |=> status_word[12])
      else $error("immediate set-point not taken");
   a_ack_queued:
      assert property (s_sp_rise ##0 !status_word[10] && !obj_req.wdata[5] |=> !status_word[12])
      else $error("queued set-point acknowledged early");
   a_ack_clear:
      assert property (obj_req.wr && obj_req.index == 16'h6040 && !obj_req.wdata[4]
         |=> !status_word[12])
      else $error("acknowledge outlived set-point bit");
   a_speed_zero:
      assert property (s_vel_steady [*2] |-> status_word[12] == (vel_actual == 0))
      else $error("speed bit wrong");
   a_slip_flag:
      assert property (s_vel_steady [*2] |-> status_word[13] == (slip_err >= sh.slip))
      else $error("slippage bit wrong");
   a_halt_reached:
      assert property ((sh.cw[8] && $stable(vel_demand)) [*2]
         |-> status_word[10] == (vel_demand == 0))
      else $error("halt target bit wrong");
endmodule

bind pmc_top pmc_top_properties #(.TICK_CYC(TICK_CYC)) i_props (
   .sys_clk(sys_clk),
   .rst_b(rst_b),
   .obj_req(obj_req),
   .obj_rsp(obj_rsp),
   .vel_actual(vel_actual),
   .power_en(power_en),
   .vel_demand(vel_demand),
   .status_word(status_word)
);

// *** verif/pmc_host_model.sv ***
// Purpose: host issuing object writes and reads
// Assumes: answer registered one cycle after the request is taken
// Notes: strobes move 1 ns after a rising edge and last one cycle
module pmc_host_model (
   input wire logic sys_clk,
   output pmc_pkg::pmc_obj_req_t obj_req,
   input wire pmc_pkg::pmc_obj_rsp_t obj_rsp
);
   timeunit 1ns;
   timeprecision 1ps;

   initial obj_req = '0;

   task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
         output logic [31:0] q, output logic rf);
      @(posedge sys_clk);
      #1;
      obj_req = {w, ~w, idx, d};
      @(posedge sys_clk);
      #1;
      obj_req.wr = 1'b0;
      obj_req.rd = 1'b0;
      q = obj_rsp.rdata;
      rf = obj_rsp.refused;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] q;
      logic rf;
      xfer(1'b1, idx, d, q, rf);
   endtask

   // polls status up to 200 times so the set-point bit is not dropped too early
   task automatic wait_ack(output logic ok);
      logic [31:0] q;
      logic rf;
      ok = 1'b0;
      for (int i = 0; i < 200 && !ok; i++) begin
         xfer(1'b0, 16'h6041, 32'h0, q, rf);
         ok = q[12];
      end
   endtask

   task automatic enable_power;
      wr(16'h6040, 32'h0006);
      wr(16'h6040, 32'h0007);
      wr(16'h6040, 32'h000F);
   endtask

   task automatic move(input logic [31:0] tgt, input logic [15:0] cw, output logic ok);
      wr(16'h607A, tgt);
      wr(16'h6040, {16'h0, cw});
      wait_ack(ok);
      wr(16'h6040, {16'h0, cw & 16'hFFEF});
   endtask
endmodule

// *** verif/testbench.sv ***
// Purpose: directed object-port tests of the motion block
// Assumes: short tick for simulation
// Notes: expected positions follow from 100 steps per tick
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 10;
   logic sys_clk;
   logic rst_b;
   logic fault_pin;
   logic signed [31:0] vel_actual;
   logic power_en;
   logic signed [31:0] vel_demand;
   logic signed [31:0] pos_demand;
   logic [15:0] status_word;
   pmc_pkg::pmc_obj_req_t obj_req;
   pmc_pkg::pmc_obj_rsp_t obj_rsp;
   int err_total;
   int n_checks;
   logic [31:0] rv;
   logic rf;
   logic ok;

   pmc_top #(.TICK_CYC(TICK)) i_dut (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .obj_req(obj_req),
      .obj_rsp(obj_rsp),
      .vel_actual(vel_actual),
      .fault_pin(fault_pin),
      .power_en(power_en),
      .vel_demand(vel_demand),
      .pos_demand(pos_demand),
      .status_word(status_word)
   );

   pmc_host_model i_host (
      .sys_clk(sys_clk),
      .obj_req(obj_req),
      .obj_rsp(obj_rsp)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ==========================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic finish_test;
      if (err_total == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic do_reset;
      rst_b = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string nm);
      i_host.xfer(1'b0, idx, 32'h0, rv, rf);
      chk(nm, exp, rv);
   endtask

   task automatic wait_sw(input int lim);
      for (int i = 0; i < lim && status_word[10] !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("target_reached", 32'h1, 32'(status_word[10]));
   endtask

   task automatic wait_vel(input logic [31:0] v, input int lim);
      for (int i = 0; i < lim && vel_demand !== v; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("vel_demand", v, vel_demand);
   endtask

   task automatic settle(input logic [31:0] v);
      vel_actual = v;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   // ==========================================
   // tests
   initial begin
      rst_b = 1'b0;
      fault_pin = 1'b0;
      vel_actual = '0;
      err_total = 0;
      n_checks = 0;
      fork
         begin
            #400000;
            err_total++;
            finish_test();
         end
      join_none
      do_reset();
      rdchk(16'h6085, 32'h00030D40, "qs_dec_reset");
      rdchk(16'h6086, 32'h0, "ptype_reset");
      i_host.xfer(1'b1, 16'h6086, 32'h1, rv, rf);
      chk("ptype_refused", 32'h1, 32'(rf));
      rdchk(16'h6086, 32'h0, "ptype_kept");
      i_host.wr(16'h6085, 32'h89ABCDEF);
      rdchk(16'h6085, 32'h89ABCDEF, "qs_dec_rw");
      i_host.xfer(1'b0, 16'h6000, 32'h0, rv, rf);
      chk("unmapped", 32'h1, 32'(rf));
      i_host.xfer(1'b1, 16'h6041, 32'h0, rv, rf);
      chk("sw_read_only", 32'h1, 32'(rf));
      i_host.wr(16'h6081, 32'd100000);
      i_host.wr(16'h6083, 32'h05F5E100);
      i_host.wr(16'h6084, 32'h05F5E100);
      i_host.enable_power();
      chk("sw_enabled", 32'h27, 32'(status_word[6:0]));
      chk("power_en", 32'h1, 32'(power_en));
      i_host.wr(16'h6060, 32'h1);
      rdchk(16'h6060, 32'h1, "mode_pos");
      i_host.move(32'd1000, 16'h001F, ok);
      chk("ack_abs", 32'h1, 32'(ok));
      wait_sw(400);
      chk("pos_abs", 32'd1000, pos_demand);
      // second target while moving must wait its turn
      i_host.move(32'd2000, 16'h001F, ok);
      i_host.wr(16'h607A, 32'd500);
      i_host.wr(16'h6040, 32'h001F);
      chk("ack_queued", 32'h0, 32'(status_word[12]));
      i_host.wait_ack(ok);
      chk("ack_later", 32'h1, 32'(ok));
      i_host.wr(16'h6040, 32'h000F);
      wait_sw(400);
      chk("pos_queued", 32'd500, pos_demand);
      i_host.move(32'd2000, 16'h001F, ok);
      i_host.wr(16'h607A, 32'd100);
      i_host.wr(16'h6040, 32'h003F);
      chk("ack_immediate", 32'h1, 32'(status_word[12]));
      i_host.wr(16'h6040, 32'h002F);
      wait_sw(400);
      chk("pos_immediate", 32'd100, pos_demand);
      for (int i = 0; i < 2; i++) begin
         i_host.move(32'd300, i ? 16'h007F : 16'h005F, ok);
         wait_sw(400);
         chk("pos_relative", 32'(400 + 300 * i), pos_demand);
      end
      for (int p = 0; p < 3; p++) begin
         do_reset();
         i_host.wr(16'h6083, 32'h05F5E100);
         i_host.wr(16'h6084, 32'h05F5E100);
         i_host.wr(16'h6085, 32'h05F5E100);
         i_host.enable_power();
         i_host.wr(16'h605A, p == 1 ? 32'h4 : 32'h2);
         i_host.wr(16'h605E, 32'h2);
         i_host.wr(16'h605D, 32'h2);
         i_host.wr(16'h6060, 32'h3);
         i_host.wr(16'h60FF, 32'd100000);
         wait_vel(32'd100000, 5 * TICK);
         if (p == 0) begin
            settle(32'd0);
            chk("speed_zero", 32'h1, 32'(status_word[12]));
            settle(32'd5);
            chk("speed_moving", 32'h0, 32'(status_word[12]));
            settle(32'd99488);
            chk("slip_at_limit", 32'h1, 32'(status_word[13]));
            settle(32'd99489);
            chk("slip_below", 32'h0, 32'(status_word[13]));
            chk("vel_window_out", 32'h0, 32'(status_word[10]));
            settle(32'd99900);
            chk("vel_window_in", 32'h1, 32'(status_word[10]));
            i_host.wr(16'h6040, 32'h010F);
            wait_vel(32'd0, 5 * TICK);
            chk("halt_reached", 32'h1, 32'(status_word[10]));
            i_host.wr(16'h6040, 32'h000F);
            wait_vel(32'd100000, 5 * TICK);
         end
         // slow profile decel makes the quick stop ramp stand out
         i_host.wr(16'h6084, 32'd1000);
         if (p == 2) begin
            fault_pin = 1'b1;
         end else begin
            i_host.wr(16'h6040, 32'h000B);
         end
         wait_vel(32'd0, 4 * TICK);
      end
      fault_pin = 1'b0;
      finish_test();
   end
endmodule
